// [core/twi_pkg.sv]
// How it works
// R1 - device samples on rise, drives on fall
// R2 - bytes travel most significant bit first
// R3 - nine clocks per byte, ack last
// R4 - data moves only while clock is low
// R5 - start wakes device, begins new command
// R6 - stop ends transfer, device to standby
// R7 - ignore everything until a start is seen
// R8 - repeated start begins a fresh command
// R9 - bus idle only when both lines high
// R10 - sender releases on eighth fall; ack low
// R11 - acker releases data at end of ninth
// R12 - master nack ends read, device releases
// R13 - standby after reset, stop, mismatch, nack
// R14 - recovery: start, nine clocks, start, stop
// R15 - storage is 128 pages of 16 bytes
// R16 - first byte top nibble is type id
// R17 - bits 3..1 high address, bit 0 read
// R18 - ack match on ninth clock, else standby
// R19 - word address byte carries low eight bits
// R20 - master alone decides byte count
// R21 - no address ack while write is busy
// R22 - device releases data unless sending or acking
package twi_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 11;
  localparam int PAGE_COUNT = 128;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_OFS_W = $clog2(PAGE_BYTES);
  // arbitrary type identifier value
  localparam logic [3:0] DEV_TYPE_ID = 4'h6;
  localparam int DA_ID_LSB = 4;
  localparam int DA_HI_MSB = 3;
  localparam int DA_HI_LSB = 1;
  localparam int DA_RW_BIT = 0;
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;
  localparam logic [3:0] ACK_CNT = 4'h8;
  localparam logic [3:0] RECOVER_START2 = 4'hA;
  localparam logic [3:0] RECOVER_LAST = 4'hB;
  localparam int CORE_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
  localparam int DIV_W = 8;

  typedef enum {ST_STANDBY, ST_DEV_ADDR, ST_WORD_ADDR, ST_WR_DATA, ST_RD_DATA} dev_state_t;
  typedef enum logic [2:0] {OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RECOVER} cmd_op_t;
  typedef enum {P_START, P_STOP, P_BIT} prim_t;

endpackage : twi_pkg

// [core/twi_link_if.sv]
`timescale 1ns/10ps
interface twi_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // pulled-up open-drain wire: any enabled low driver pulls it down
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : twi_link_if

// [core/twi_eeprom_dev.sv]
`timescale 1ns/10ps
module twi_eeprom_dev #(
  parameter int ADDR_W = twi_pkg::ADDR_W,
  parameter logic [3:0] TYPE_ID = twi_pkg::DEV_TYPE_ID
) (
  // reset
  input wire logic SYS_RST,
  // link
  twi_link_if.dev LINK,
  // storage side
  input wire logic BUSY,
  input wire logic [7:0] RD_DATA,
  output logic [ADDR_W-1:0] BYTE_ADDR,
  output logic [7:0] WR_DATA,
  output logic WR_TOGGLE,
  output logic STOP_TOGGLE,
  // status
  output logic STANDBY,
  output logic READ_MODE
);

  logic start_tog_q;
  logic stop_tog_q;
  logic start_seen_q;
  logic stop_seen_q;
  twi_pkg::dev_state_t st_q;
  twi_pkg::dev_state_t st_d;
  logic standby_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic ack_q;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wr_data_q;
  logic wr_tog_q;
  logic busy_m_q;
  logic busy_s_q;
  logic drv_low_q;
  logic [7:0] tx_q;
  logic [7:0] rx_byte;
  logic start_pend;
  logic stop_pend;
  logic live;

  function automatic logic id_match(input logic [7:0] b);
    id_match = (b[7:twi_pkg::DA_ID_LSB] == TYPE_ID); // [R16]
  endfunction : id_match

  // low four bits wrap inside the page, page bits held
  function automatic logic [ADDR_W-1:0] page_next(input logic [ADDR_W-1:0] a);
    page_next = {a[ADDR_W-1:twi_pkg::PAGE_OFS_W],
                 a[twi_pkg::PAGE_OFS_W-1:0] + 4'h1}; // [R15]
  endfunction : page_next

  assign rx_byte = {sh_q[6:0], LINK.sda}; // [R2]
  assign start_pend = start_tog_q ^ start_seen_q;
  assign stop_pend = stop_tog_q ^ stop_seen_q;
  assign live = !start_pend && !stop_pend && st_q != twi_pkg::ST_STANDBY;

  assign LINK.dev_sda_o = 1'b0;
  assign LINK.dev_sda_oe = drv_low_q;
  assign BYTE_ADDR = addr_q;
  assign WR_DATA = wr_data_q;
  assign WR_TOGGLE = wr_tog_q;
  assign STOP_TOGGLE = stop_tog_q;
  assign STANDBY = standby_q;
  assign READ_MODE = rd_q;

  // start: data falls while clock high; toggles survive a stopped clock
  always_ff @(negedge LINK.sda or posedge SYS_RST)
  begin
    if (SYS_RST)
      start_tog_q <= 1'b0;
    else if (LINK.scl)
      start_tog_q <= ~start_tog_q; // [R4] [R5]
  end

  // stop: data rises while clock high
  always_ff @(posedge LINK.sda or posedge SYS_RST)
  begin
    if (SYS_RST)
      stop_tog_q <= 1'b0;
    else if (LINK.scl)
      stop_tog_q <= ~stop_tog_q; // [R4] [R6]
  end

  // toggles are read on the next clock rise without a second stage:
  // start hold and setup times leave them settled long before it
  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end
    else
    begin
      start_seen_q <= start_tog_q;
      stop_seen_q <= stop_tog_q;
    end
  end

  // busy comes from the storage domain; only read at the address byte
  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      busy_m_q <= 1'b0;
      busy_s_q <= 1'b0;
    end
    else
    begin
      busy_m_q <= BUSY;
      busy_s_q <= busy_m_q;
    end
  end

  always_comb
  begin
    st_d = st_q;
    if (start_pend)
      st_d = twi_pkg::ST_DEV_ADDR; // [R5] [R8]
    else if (!live)
      st_d = twi_pkg::ST_STANDBY; // [R6] [R7] [R13]
    else if (cnt_q == twi_pkg::ACK_CNT)
    begin
      unique case (st_q)
        twi_pkg::ST_DEV_ADDR:
          if (!ack_q)
            st_d = twi_pkg::ST_STANDBY; // [R18]
          else if (rd_q)
            st_d = twi_pkg::ST_RD_DATA;
          else
            st_d = twi_pkg::ST_WORD_ADDR; // [R19]
        twi_pkg::ST_WORD_ADDR:
          st_d = twi_pkg::ST_WR_DATA;
        twi_pkg::ST_RD_DATA:
          if (LINK.sda)
            st_d = twi_pkg::ST_STANDBY; // [R12]
        twi_pkg::ST_WR_DATA,
        twi_pkg::ST_STANDBY:
          st_d = st_q; // [R20]
      endcase
    end
  end

  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_q <= twi_pkg::ST_STANDBY;
      standby_q <= 1'b1; // [R13]
    end
    else
    begin
      st_q <= st_d;
      standby_q <= (st_d == twi_pkg::ST_STANDBY);
    end
  end

  // bit counter and shifter, sampled on the rise
  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end
    else if (start_pend)
    begin
      cnt_q <= 4'h1;
      sh_q <= {7'h00, LINK.sda}; // [R1]
    end
    else if (live)
    begin
      sh_q <= rx_byte; // [R1] [R2]
      cnt_q <= (cnt_q == twi_pkg::ACK_CNT) ? 4'h0 : cnt_q + 4'h1; // [R3]
    end
  end

  // ack decision made on the eighth rise, driven on the next fall
  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ack_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (start_pend)
      ack_q <= 1'b0;
    else if (live && cnt_q == twi_pkg::LAST_BIT_CNT)
    begin
      unique case (st_q)
        twi_pkg::ST_DEV_ADDR:
        begin
          ack_q <= id_match(rx_byte) && !busy_s_q; // [R18] [R21]
          rd_q <= rx_byte[twi_pkg::DA_RW_BIT]; // [R17]
        end
        twi_pkg::ST_WORD_ADDR,
        twi_pkg::ST_WR_DATA:
          ack_q <= 1'b1;
        twi_pkg::ST_RD_DATA,
        twi_pkg::ST_STANDBY:
          ack_q <= 1'b0;
      endcase
    end
  end

  // address pointer: reads step after each byte, writes wrap in page
  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
      addr_q <= '0;
    else if (live && cnt_q == twi_pkg::LAST_BIT_CNT)
    begin
      if (st_q == twi_pkg::ST_DEV_ADDR && id_match(rx_byte) && !busy_s_q)
        addr_q[ADDR_W-1:ADDR_W-3] <= rx_byte[twi_pkg::DA_HI_MSB:twi_pkg::DA_HI_LSB]; // [R17]
      else if (st_q == twi_pkg::ST_WORD_ADDR)
        addr_q[7:0] <= rx_byte; // [R19]
      else if (st_q == twi_pkg::ST_RD_DATA)
        addr_q <= addr_q + ADDR_W'(1); // [R15]
    end
    else if (live && cnt_q == twi_pkg::ACK_CNT && st_q == twi_pkg::ST_WR_DATA)
      addr_q <= page_next(addr_q);
  end

  // write byte handed to storage with a toggle, address still valid
  always_ff @(posedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_data_q <= 8'h00;
      wr_tog_q <= 1'b0;
    end
    else if (live && cnt_q == twi_pkg::LAST_BIT_CNT && st_q == twi_pkg::ST_WR_DATA)
    begin
      wr_data_q <= rx_byte;
      wr_tog_q <= ~wr_tog_q;
    end
  end

  // line driver: changes only on the fall
  always_ff @(negedge LINK.scl or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      drv_low_q <= 1'b0;
      tx_q <= 8'h00;
    end
    else if (!live)
      drv_low_q <= 1'b0; // [R22] [R7]
    else if (cnt_q == twi_pkg::ACK_CNT)
      drv_low_q <= ack_q; // [R10] [R18]
    else if (st_q == twi_pkg::ST_RD_DATA && cnt_q == 4'h0)
    begin
      drv_low_q <= !RD_DATA[7]; // [R1] [R2]
      tx_q <= {RD_DATA[6:0], 1'b0};
    end
    else if (st_q == twi_pkg::ST_RD_DATA)
    begin
      drv_low_q <= !tx_q[7]; // [R2] [R4]
      tx_q <= {tx_q[6:0], 1'b0};
    end
    else
      drv_low_q <= 1'b0; // [R11] [R22]
  end

endmodule : twi_eeprom_dev

// [core/twi_master_host.sv]
`timescale 1ns/10ps
module twi_master_host #(
  parameter int QUARTER_CYC = twi_pkg::QUARTER_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // link
  twi_link_if.host LINK,
  // command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire twi_pkg::cmd_op_t CMD_OP,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_NACK,
  // answer
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ACK,
  output logic BUS_IDLE
);

  logic [twi_pkg::DIV_W-1:0] div_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [3:0] step_q;
  logic ready_q;
  logic rsp_valid_q;
  logic ack_q;
  logic nack_q;
  logic scl_q;
  logic sda_oe_q;
  logic sda_m_q;
  logic sda_s_q;
  logic idle_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  twi_pkg::cmd_op_t op_q;
  twi_pkg::prim_t prim;
  logic tick;
  logic prim_done;
  logic q0_low;

  assign LINK.scl = scl_q;
  assign LINK.host_sda_o = 1'b0;
  assign LINK.host_sda_oe = sda_oe_q;
  assign CMD_READY = ready_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA = rx_q;
  assign RSP_ACK = ack_q;
  assign BUS_IDLE = idle_q;
  assign tick = (div_q == '0);

  always_comb
  begin
    unique case (op_q)
      twi_pkg::OP_START: prim = twi_pkg::P_START;
      twi_pkg::OP_STOP: prim = twi_pkg::P_STOP;
      twi_pkg::OP_WRITE, twi_pkg::OP_READ: prim = twi_pkg::P_BIT;
      twi_pkg::OP_RECOVER:
        if (step_q == 4'h0 || step_q == twi_pkg::RECOVER_START2)
          prim = twi_pkg::P_START; // [R14]
        else if (step_q == twi_pkg::RECOVER_LAST)
          prim = twi_pkg::P_STOP; // [R14]
        else
          prim = twi_pkg::P_BIT;
      default: prim = twi_pkg::P_BIT;
    endcase
  end

  assign prim_done = prim != twi_pkg::P_BIT || op_q == twi_pkg::OP_RECOVER
                     || bit_q == twi_pkg::ACK_CNT; // [R3]

  // level set in the first quarter, while the clock is low
  always_comb
  begin
    q0_low = 1'b0; // [R8] [R11]
    if (prim == twi_pkg::P_STOP)
      q0_low = 1'b1;
    else if (prim == twi_pkg::P_BIT && op_q == twi_pkg::OP_WRITE)
      q0_low = bit_q != twi_pkg::ACK_CNT && !sh_q[7]; // [R2] [R10]
    else if (prim == twi_pkg::P_BIT && op_q == twi_pkg::OP_READ)
      q0_low = bit_q == twi_pkg::ACK_CNT && !nack_q; // [R10] [R12]
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      idle_q <= 1'b0;
    end
    else
    begin
      sda_m_q <= LINK.sda;
      sda_s_q <= sda_m_q;
      idle_q <= scl_q && sda_s_q; // [R9]
    end
  end

  // clock divider: one tick per quarter of the bus clock
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      div_q <= twi_pkg::DIV_W'(QUARTER_CYC - 1);
    else if (!ready_q && !tick)
      div_q <= div_q - 1'b1;
    else
      div_q <= twi_pkg::DIV_W'(QUARTER_CYC - 1);
  end

  // no clock stretching: the far end is assumed never to hold the clock
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      step_q <= 4'h0;
      op_q <= twi_pkg::OP_START;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      if (ready_q && CMD_VALID)
      begin
        ready_q <= 1'b0;
        op_q <= CMD_OP;
        sh_q <= CMD_DATA;
        nack_q <= CMD_NACK;
        qtr_q <= 2'h0;
        bit_q <= 4'h0;
        step_q <= 4'h0;
      end
      else if (!ready_q && tick)
      begin
        qtr_q <= qtr_q + 2'h1;
        unique case (qtr_q)
          2'h0: sda_oe_q <= q0_low; // [R4]
          2'h1: scl_q <= 1'b1;
          2'h2:
            if (prim == twi_pkg::P_START)
              sda_oe_q <= 1'b1; // [R8]
            else if (prim == twi_pkg::P_STOP)
              sda_oe_q <= 1'b0;
            else if (bit_q == twi_pkg::ACK_CNT)
              ack_q <= !sda_s_q; // [R10]
            else
              rx_q <= {rx_q[6:0], sda_s_q}; // [R2]
          2'h3:
          begin
            if (prim != twi_pkg::P_STOP)
              scl_q <= 1'b0;
            if (!prim_done)
            begin
              bit_q <= bit_q + 4'h1; // [R3]
              sh_q <= {sh_q[6:0], 1'b0};
            end
            else if (op_q == twi_pkg::OP_RECOVER && step_q != twi_pkg::RECOVER_LAST)
            begin
              step_q <= step_q + 4'h1; // [R14]
              bit_q <= 4'h0;
            end
            else
            begin
              ready_q <= 1'b1; // [R20]
              rsp_valid_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule : twi_master_host

// [verif/twi_assertions.sv]
`timescale 1ns/10ps
module twi_assertions (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  logic scl_q, sda_q, first_q, rd_q, nacked_q, rise, fall, start, stop;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  // the wires are slow against the core clock, so edges are seen on samples
  assign rise = scl && !scl_q;
  assign fall = !scl && scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bit position within the byte and whether the device is sending
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      nacked_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      rd_q <= 1'b0;
      nacked_q <= 1'b0;
    end
    else if (stop)
      rd_q <= 1'b0;
    else if (rise)
    begin
      cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
      if (cnt_q == 4'h8)
        first_q <= 1'b0;
      if (cnt_q == 4'h8 && first_q && sh_q[0] && !sda)
        rd_q <= 1'b1;
      // after a master nack the device has left the byte stream, so a
      // recovery start may fall anywhere in the clock count
      if (cnt_q == 4'h8 && rd_q && !first_q && sda)
        nacked_q <= 1'b1;
    end
  end
  sequence s_addr_end;
    fall && cnt_q == 4'h8 && first_q;
  endsequence
  sequence s_master_nack;
    rise && cnt_q == 4'h8 && rd_q && !first_q && sda;
  endsequence
  a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device enable moved with clock high");
  a_no_dev_edge: assert property (scl && scl_q && sda != sda_q |-> !dev_sda_oe)
    else $error("device made a data edge with clock high");
  a_host_byte_whole: assert property ($changed(host_sda_oe) && scl && scl_q && !nacked_q
    |-> cnt_q == 4'h0 || cnt_q == 4'h1)
    else $error("host framed a condition inside a byte");
  a_dev_drive_slot: assert property ($rose(dev_sda_oe) |-> cnt_q == 4'h8 || rd_q)
    else $error("device drove outside its slots");
  a_ack_release: assert property (fall && cnt_q == 4'h9 && !rd_q |-> !dev_sda_oe)
    else $error("ack not released after ninth clock");
  a_read_release: assert property (fall && cnt_q == 4'h8 && rd_q && !first_q
    |-> !dev_sda_oe)
    else $error("read byte not released at eighth fall");
  a_nack_quiet: assert property (s_master_nack |=> !dev_sda_oe [*8] ##1 !dev_sda_oe [*8])
    else $error("device drove after master nack");
  a_id_mismatch: assert property (s_addr_end ##0 sh_q[7:4] != twi_pkg::DEV_TYPE_ID
    |-> !dev_sda_oe)
    else $error("foreign address acknowledged");
endmodule : twi_assertions

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_nack = 1'b0;
  logic busy = 1'b0;
  twi_pkg::cmd_op_t cmd_op = twi_pkg::OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] lfsr_q = 8'h2C;
  logic [7:0] rd_data, rsp_data, wr_data;
  logic cmd_ready, rsp_valid, rsp_ack, bus_idle, wr_tgl, stop_tgl, standby, read_mode;
  logic [10:0] byte_addr;
  logic [7:0] dev_mem [2048];
  int exp_mem [2048];
  int n_mismatch = 0;
  int n_tests = 0;
  int ptr = 0;
  int n_stop = 0;
  twi_link_if link ();
  always #2.5 clk = !clk;
  // storage follows the pointer at once, well inside half a bus period
  assign rd_data = dev_mem[byte_addr];
  always @(wr_tgl)
  begin
    #1;
    if (!rst)
      dev_mem[byte_addr] = wr_data;
  end
  twi_master_host #(.QUARTER_CYC(4)) u_twi_master_host (.CORE_CLK(clk), .SYS_RST(rst),
    .LINK(link), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_DATA(cmd_data), .CMD_NACK(cmd_nack), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_ACK(rsp_ack), .BUS_IDLE(bus_idle));
  twi_eeprom_dev u_twi_eeprom_dev (.SYS_RST(rst), .LINK(link), .BUSY(busy),
    .RD_DATA(rd_data), .BYTE_ADDR(byte_addr), .WR_DATA(wr_data), .WR_TOGGLE(wr_tgl),
    .STOP_TOGGLE(stop_tgl), .STANDBY(standby), .READ_MODE(read_mode));
  twi_assertions u_twi_assertions (.CORE_CLK(clk), .SYS_RST(rst), .scl(link.scl),
    .sda(link.sda), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  function automatic logic [7:0] dab(input int a, input logic r);
    return {twi_pkg::DEV_TYPE_ID, 3'(a >> 8), r};
  endfunction : dab
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic cmd(input twi_pkg::cmd_op_t op, input logic [7:0] d, input logic nk);
    int i;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    chk(11'(cmd_ready), 11'h000);
    for (i = 0; i < 4000; i++)
    begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1)
        break;
    end
    if (i == 4000)
    begin
      n_mismatch++;
      complete_run();
    end
    chk(11'(cmd_ready), 11'h001);
  endtask : cmd
  task automatic st();
    cmd(twi_pkg::OP_START, 8'h00, 1'b0);
  endtask : st
  task automatic sp();
    cmd(twi_pkg::OP_STOP, 8'h00, 1'b0);
    n_stop++;
  endtask : sp
  task automatic wb(input logic [7:0] d, input logic ea);
    cmd(twi_pkg::OP_WRITE, d, 1'b0);
    chk(11'(rsp_ack), 11'(ea));
  endtask : wb
  task automatic rb(input logic nk);
    int e;
    e = exp_mem[ptr];
    cmd(twi_pkg::OP_READ, 8'h00, nk);
    chk(11'(rsp_data), 11'(e));
    ptr = (ptr + 1) % 2048;
  endtask : rb
  task automatic rd_seq(input int ad, input int cnt);
    int k;
    st();
    wb(dab(ad, 1'b0), 1'b1);
    wb(8'(ad), 1'b1);
    st();
    wb(dab(ad, 1'b1), 1'b1);
    ptr = ad;
    for (k = 0; k < cnt; k++)
      rb(k == cnt - 1);
    chk(11'(standby), 11'h001);
    sp();
  endtask : rd_seq
  initial
  begin
    int a, n;
    for (a = 0; a < 2048; a++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      dev_mem[a] = lfsr_q;
      exp_mem[a] = lfsr_q;
    end
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(11'(standby), 11'h001);
    lfsr_q = lfsr_next(lfsr_q);
    a = {lfsr_q[6:0], 4'hE};
    st();
    wb(dab(a, 1'b0), 1'b1);
    wb(8'(a), 1'b1);
    for (n = 0; n < 3; n++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      wb(lfsr_q, 1'b1);
      exp_mem[(a & 2032) | ((a + n) & 15)] = lfsr_q;
    end
    chk(byte_addr, 11'((a & 2032) | ((a + 3) & 15)));
    chk(11'(wr_data), 11'(lfsr_q));
    sp();
    chk(11'(bus_idle), 11'h001);
    rd_seq(a, 2);
    rd_seq(a & 2032, 1);
    rd_seq(2046, 3);
    st();
    wb(dab(ptr, 1'b1), 1'b1);
    chk(11'(read_mode), 11'h001);
    rb(1'b1);
    sp();
    st();
    wb({~twi_pkg::DEV_TYPE_ID, 4'h0}, 1'b0);
    chk(11'(standby), 11'h001);
    wb(lfsr_q, 1'b0);
    sp();
    busy = 1'b1;
    st();
    wb(dab(0, 1'b0), 1'b0);
    sp();
    busy = 1'b0;
    st();
    wb(dab(0, 1'b0), 1'b1);
    sp();
    st();
    wb(dab(ptr, 1'b1), 1'b1);
    cmd(twi_pkg::OP_RECOVER, 8'h00, 1'b0);
    n_stop++;
    st();
    wb(dab(0, 1'b0), 1'b1);
    sp();
    chk(11'(stop_tgl), 11'(n_stop & 1));
    complete_run();
  end
endmodule : testbench
